// file: mem_if.sv
// processor-side memory interface: clocks, dram cycle choice, abort
`timescale 1ns/1ps
module mem_if (
  input wire logic clk_in, // 40 MHz master clock
  input wire logic rst_in, // synchronous, active high
  input wire mem_if_pkg::cpu_req_t req_in, // processor address and control
  output logic phase1_out, // processor clock phase one
  output logic phase2_out, // processor clock phase two
  output logic ref_clk_out, // bus reference clock
  output mem_if_pkg::dram_ctl_t dram_out, // strobes and effective address
  output logic data_bus_drive_enable_out, // processor may drive data
  output logic abort_out // current access aborts
);
  //////////////////////////////////////////////////////////////////////
  // pins from the processor pass two flops first
  mem_if_pkg::cpu_req_t sync1, req;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // all-zero would read as a live request straight out of reset
      sync1 <= mem_if_pkg::REQ_IDLE;
      req <= mem_if_pkg::REQ_IDLE;
    end else begin
      sync1 <= req_in;
      req <= sync1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // divide by three; phases are one-count pulses with a gap count after phase one only
  logic [1:0] div;
  always_ff @(posedge clk_in) begin
    if (rst_in) div <= 2'h0;
    else if (div == mem_if_pkg::DIV_LAST) div <= 2'h0;
    else div <= div + 2'h1;
  end
  wire tick_ph1 = (div == mem_if_pkg::PH1_TICK);
  wire tick_ph2 = (div == mem_if_pkg::PH2_TICK);
  wire cycle_end = tick_ph2; // processor cycle closes with phase two

  // registered phases: never both high, a gap count after phase one, none after phase two
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase1_out <= 1'b0;
      phase2_out <= 1'b0;
      ref_clk_out <= 1'b0;
    end else begin
      phase1_out <= tick_ph1;
      phase2_out <= tick_ph2;
      ref_clk_out <= tick_ph2;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // address decode: word ignores low bits, byte write picks a lane
  wire is_word = req.byte_n_word;
  wire is_write = req.rd_n_wr;
  wire [25:0] eff_addr = is_word ? {req.addr[25:2], 2'h0}
                                 : req.addr;
  wire [3:0] lane_sel = 4'h1 << req.addr[1:0];
  wire [3:0] lanes = (is_word || !is_write) ? mem_if_pkg::ALL_LANES
                                             : lane_sel;
  // a page boundary is crossed when the word index wraps to zero
  wire boundary = (req.addr[3:2] == 2'h0);
  wire want = !req.memory_request_n;
  wire is_seq = req.sequential_hint && !boundary;
  wire prot_hit = (req.addr >= mem_if_pkg::PROT_BASE);
  wire no_page = (req.addr >= mem_if_pkg::PHYS_TOP);
  // supervisor mode bypasses remapping, so only user mode faults
  wire fault = want && ((!req.supervisor_select && prot_hit)
               || (!req.supervisor_select && no_page));

  //////////////////////////////////////////////////////////////////////
  // dram sequencer: row then column for random, column only for page
  mem_if_pkg::cyc_state_t state, next_state;
  logic internal_cyc;
  always_comb begin
    next_state = state;
    case (state)
      mem_if_pkg::ST_IDLE: begin
        // early start overlaps internal cycle with row half
        if (want && req.sequential_hint && internal_cyc && !fault)
          next_state = mem_if_pkg::ST_ROW;
        else if (cycle_end && want && !fault)
          next_state = mem_if_pkg::ST_ROW;
      end
      mem_if_pkg::ST_ROW: begin
        if (cycle_end) next_state = mem_if_pkg::ST_COL;
      end
      mem_if_pkg::ST_COL: begin
        if (cycle_end) begin
          if (!want || fault) next_state = mem_if_pkg::ST_IDLE;
          else if (is_seq) next_state = mem_if_pkg::ST_COL;
          else next_state = mem_if_pkg::ST_IDLE;
        end
      end
      default: next_state = mem_if_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= mem_if_pkg::ST_IDLE;
      internal_cyc <= 1'b1;
    end else begin
      state <= next_state;
      if (cycle_end) internal_cyc <= !want;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // strobe outputs; cas drops for one count at each cycle end (precharge)
  wire col_gap = cycle_end; // page mode: cas released, ras kept
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dram_out <= '{ras_n: 1'b1, cas_n: 4'hF, eff_addr: '0};
      data_bus_drive_enable_out <= 1'b0;
      abort_out <= 1'b0;
    end else begin
      dram_out.ras_n <= (next_state == mem_if_pkg::ST_IDLE);
      dram_out.cas_n <= (next_state == mem_if_pkg::ST_COL && !col_gap)
                        ? ~lanes : 4'hF;
      dram_out.eff_addr <= eff_addr;
      data_bus_drive_enable_out <= want && is_write && !fault;
      abort_out <= fault;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_phase_nonoverlap;
    @(posedge clk_in) disable iff (rst_in) !(phase1_out && phase2_out);
  endproperty
  a_phase_nonoverlap: assert property (p_phase_nonoverlap)
    else $error("phases overlap");
  property p_phase_period;
    @(posedge clk_in) disable iff (rst_in)
      $rose(phase2_out) |=> !phase2_out ##1 !phase2_out ##1 phase2_out;
  endproperty
  a_phase_period: assert property (p_phase_period)
    else $error("phase two period not three");
  property p_ref_track;
    @(posedge clk_in) disable iff (rst_in) ref_clk_out == phase2_out;
  endproperty
  a_ref_track: assert property (p_ref_track)
    else $error("reference clock not with phase two");
  property p_dbe_write;
    @(posedge clk_in) disable iff (rst_in)
      data_bus_drive_enable_out |-> $past(is_write) && $past(want);
  endproperty
  a_dbe_write: assert property (p_dbe_write)
    else $error("drive enable outside write");
  property p_abort_cause;
    @(posedge clk_in) disable iff (rst_in) abort_out == $past(fault);
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort not tied to fault");
  property p_no_dbe_abort;
    @(posedge clk_in) disable iff (rst_in)
      abort_out |-> !data_bus_drive_enable_out;
  endproperty
  a_no_dbe_abort: assert property (p_no_dbe_abort)
    else $error("drive enabled during abort");
  property p_word_aligned;
    @(posedge clk_in) disable iff (rst_in)
      is_word |-> eff_addr[1:0] == 2'h0;
  endproperty
  a_word_aligned: assert property (p_word_aligned)
    else $error("word address not aligned");
  property p_byte_lane;
    @(posedge clk_in) disable iff (rst_in)
      (!is_word && is_write) |-> $countones(lanes) == 1;
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte write strobes several lanes");
  property p_cas_needs_ras;
    @(posedge clk_in) disable iff (rst_in)
      (dram_out.cas_n != 4'hF) |-> !dram_out.ras_n;
  endproperty
  a_cas_needs_ras: assert property (p_cas_needs_ras)
    else $error("column strobe without row strobe");
  property p_idle_no_ras;
    @(posedge clk_in) disable iff (rst_in)
      (state == mem_if_pkg::ST_IDLE && next_state == mem_if_pkg::ST_IDLE)
      |=> dram_out.ras_n;
  endproperty
  a_idle_no_ras: assert property (p_idle_no_ras)
    else $error("row strobe held while idle");

  // sequencer checks: starts, refusals, page mode and release, then byte lane and read drive
  property p_early_start;
    @(posedge clk_in) disable iff (rst_in)
      (state == mem_if_pkg::ST_IDLE && want && req.sequential_hint
       && internal_cyc && !fault) |=> state == mem_if_pkg::ST_ROW;
  endproperty
  a_early_start: assert property (p_early_start)
    else $error("hinted request after internal cycle not started");
  property p_no_req_idle;
    @(posedge clk_in) disable iff (rst_in)
      (state == mem_if_pkg::ST_IDLE && !want)
      |=> state == mem_if_pkg::ST_IDLE;
  endproperty
  a_no_req_idle: assert property (p_no_req_idle)
    else $error("dram cycle started without a request");
  property p_fault_no_start;
    @(posedge clk_in) disable iff (rst_in)
      (state == mem_if_pkg::ST_IDLE && fault)
      |=> state == mem_if_pkg::ST_IDLE;
  endproperty
  a_fault_no_start: assert property (p_fault_no_start)
    else $error("dram cycle started for a refused access");
  property p_page_keeps_ras;
    @(posedge clk_in) disable iff (rst_in)
      (state == mem_if_pkg::ST_COL && cycle_end && want && !fault && is_seq)
      |=> !dram_out.ras_n && dram_out.cas_n == 4'hF;
  endproperty
  a_page_keeps_ras: assert property (p_page_keeps_ras)
    else $error("page cycle did not keep row and drop column");
  property p_random_release;
    @(posedge clk_in) disable iff (rst_in)
      (state == mem_if_pkg::ST_COL && cycle_end && !is_seq)
      |=> dram_out.ras_n && dram_out.cas_n == 4'hF;
  endproperty
  a_random_release: assert property (p_random_release)
    else $error("strobes not released before random cycle");
  property p_cas_byte_lane;
    @(posedge clk_in) disable iff (rst_in)
      (next_state == mem_if_pkg::ST_COL && !col_gap && !is_word && is_write)
      |=> dram_out.cas_n == ~(4'h1 << $past(req.addr[1:0]));
  endproperty
  a_cas_byte_lane: assert property (p_cas_byte_lane)
    else $error("byte write strobed the wrong lane");
  property p_read_no_drive;
    @(posedge clk_in) disable iff (rst_in)
      !is_write |=> !data_bus_drive_enable_out;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive)
    else $error("drive enable raised on a read");

  // scenarios worth seeing at least once
  c_page: cover property (@(posedge clk_in) disable iff (rst_in)
    state == mem_if_pkg::ST_COL ##1 (state == mem_if_pkg::ST_COL) [*4]);
  c_early: cover property (@(posedge clk_in) disable iff (rst_in)
    state == mem_if_pkg::ST_IDLE && want && internal_cyc);
  c_abort: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(abort_out));
  c_write: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(data_bus_drive_enable_out));
endmodule

// file: mem_if_pkg.sv
// package for the processor-side memory interface: constants and types
//
// Contract
// - word transfers ignore two lowest address bits
// - address bits three and two mark boundaries
// - read-not-write low reads, high writes
// - byte-not-word low is byte, high word
// - byte transfers select lane from low bits (here only byte writes do; byte reads strobe all lanes)
// - memory request low starts access, high idles
// - request plus hint in internal cycle starts random
// - hint high gives one-clock page cycle
// - hint low releases strobes, two-clock random
// - supervisor low denies protected regions, aborts
// - supervisor select skips remapping outside user
// - two non-overlapping phases at master over three
// - phase two in phase with reference clock
// - drive enable high only on writes
// - abort on privilege or missing page
// - reference clock tracks phase two
package mem_if_pkg;
  localparam int ADDR_W = 26;
  localparam logic [1:0] DIV_LAST = 2'h2; // divide by three: counts 0..2
  localparam logic [1:0] PH1_TICK = 2'h0;
  localparam logic [1:0] PH2_TICK = 2'h2;
  localparam logic [3:0] ALL_LANES = 4'hF;
  // protected region: logical addresses at or above this need supervisor
  localparam logic [ADDR_W-1:0] PROT_BASE = 26'h2000000;
  // regions beyond physical span that are not logical pages
  localparam logic [ADDR_W-1:0] PHYS_TOP = 26'h3800000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ROW = 3'h2,
    ST_COL = 3'h4
  } cyc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd_n_wr; // low read, high write
    logic byte_n_word; // low byte, high word
    logic memory_request_n;
    logic sequential_hint;
    logic supervisor_select;
  } cpu_req_t;
  // pin levels held in the synchronisers during reset: no request
  localparam cpu_req_t REQ_IDLE = '{addr: '0, rd_n_wr: 1'b0,
    byte_n_word: 1'b0, memory_request_n: 1'b1, sequential_hint: 1'b0,
    supervisor_select: 1'b0};

  typedef struct packed {
    logic ras_n;
    logic [3:0] cas_n;
    logic [ADDR_W-1:0] eff_addr;
  } dram_ctl_t;
endpackage

// file: proc_model.sv
// processor stand-in: drives the reference, steps the address
`timescale 1ns/1ps
module proc_model (
  input wire logic clk_in, // master clock
  input wire logic phase2_in, // processor phase two
  input wire mem_if_pkg::cpu_req_t cmd_in, // reference from bench
  input wire logic step_in, // walk word addresses upward
  output mem_if_pkg::cpu_req_t req_out // pins to the interface
);
  // idle until the bench asks for something
  initial begin
    req_out = '0;
    req_out.memory_request_n = 1'b1;
  end
  // next reference: the bench's, or the following word when stepping
  mem_if_pkg::cpu_req_t next_req;
  always_comb begin
    next_req = cmd_in;
    if (step_in) begin
      next_req.addr = req_out.addr + 26'h0000004;
      next_req.sequential_hint = 1'b1;
    end
  end
  // change only while phase two is high, so it holds while low
  always @(negedge clk_in) begin
    if (phase2_in) req_out <= next_req;
  end
endmodule

// file: tb_processor_side_memory_interface.sv
// self-checking bench for the processor-side memory interface
`timescale 1ns/1ps
module tb_processor_side_memory_interface;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic step = 1'b0;
  mem_if_pkg::cpu_req_t cmd = '0;
  mem_if_pkg::cpu_req_t req;
  mem_if_pkg::dram_ctl_t dram;
  logic ph1, ph2, rclk, dbe, abort;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 32'h148b;
  int n;
  int ras_idle;
  always #12.5 clk_in = ~clk_in;
  proc_model i_proc (.clk_in(clk_in), .phase2_in(ph2), .cmd_in(cmd),
    .step_in(step), .req_out(req));
  mem_if i_dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .phase1_out(ph1), .phase2_out(ph2), .ref_clk_out(rclk),
    .dram_out(dram), .data_bus_drive_enable_out(dbe), .abort_out(abort));
  ////////////////////////////////////////////////////////////////////////
  // expectations: user access at or above the protected base must abort
  function automatic logic exp_abort(mem_if_pkg::cpu_req_t r);
    return !r.memory_request_n && !r.supervisor_select &&
      r.addr >= mem_if_pkg::PROT_BASE;
  endfunction
  function automatic logic [3:0] exp_lanes(mem_if_pkg::cpu_req_t r);
    if (!r.byte_n_word && r.rd_n_wr) return ~(4'h1 << r.addr[1:0]);
    return 4'h0;
  endfunction
  // words drop the two byte bits, bytes keep the full address
  function automatic logic [25:0] exp_eff(mem_if_pkg::cpu_req_t r);
    if (r.byte_n_word) return {r.addr[25:2], 2'h0};
    return r.addr;
  endfunction
  // all comparisons end here; case inequality, so an x matches only an x
  task automatic chk26(input logic [25:0] got, input logic [25:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk26({25'h0, got}, {25'h0, exp});
  endtask
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    chk26({22'h0, got}, {22'h0, exp});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hold one reference long enough to pass the input synchronisers
  task automatic run_case(input mem_if_pkg::cpu_req_t r);
    logic ab;
    ab = exp_abort(r);
    cmd <= r;
    repeat (9) @(negedge clk_in);
    repeat (6) begin
      chk1(abort, ab);
      chk1(dbe, r.rd_n_wr && !r.memory_request_n && !ab);
      chk1(rclk, ph2);
      chk1(ph1 && ph2, 1'b0);
      if (r.memory_request_n || ab) begin
        chk4({dram.ras_n, dram.cas_n}, 4'hF);
      end else if (dram.cas_n != 4'hF) begin
        chk4(dram.cas_n, exp_lanes(r));
        chk26(26'(dram.eff_addr[1:0]), exp_eff(r) & 26'h0000003);
      end
      if (!step) chk26(dram.eff_addr, exp_eff(r));
      @(negedge clk_in);
    end
  endtask
  // a hang is cut short well past the expected run length
  initial begin
    #(25 * 20000);
    miscompares++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence: corners first, then random references
  initial begin
    mem_if_pkg::cpu_req_t r;
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    r = '0;
    r.addr = mem_if_pkg::PROT_BASE - 26'h1;
    run_case(r);
    r.addr = mem_if_pkg::PROT_BASE;
    run_case(r);
    r.addr = mem_if_pkg::PHYS_TOP;
    r.rd_n_wr = 1'b1;
    run_case(r);
    r.supervisor_select = 1'b1;
    run_case(r);
    for (int i = 0; i < 4; i++) begin
      r = '0;
      r.rd_n_wr = 1'b1;
      r.addr = 26'h0000100 + 26'(i);
      run_case(r);
    end
    for (int i = 0; i < 40; i++) begin
      r = mem_if_pkg::cpu_req_t'(31'($random(seed)));
      r.memory_request_n = ($random(seed) & 7) == 0;
      r.sequential_hint = 1'b0;
      run_case(r);
    end
    // an internal cycle, then a hinted request that starts at once
    r = '0;
    r.memory_request_n = 1'b1;
    run_case(r);
    r.memory_request_n = 1'b0;
    r.byte_n_word = 1'b1;
    r.sequential_hint = 1'b1;
    run_case(r);
    // sequential word stream: page mode until every fourth word
    step <= 1'b1;
    run_case(r);
    repeat (12) @(negedge clk_in);
    n = 0;
    ras_idle = 0;
    repeat (36) begin
      @(negedge clk_in);
      n += ph2;
      ras_idle += dram.ras_n;
    end
    chk26(26'(n), 26'h000000C);
    chk26(26'(ras_idle), 26'h0000009);
    report_and_stop();
  end
endmodule
